// file: rpis_map.vh
// Register map and constants of the remappable input pin select block.
`ifndef RPIS_MAP_VH
`define RPIS_MAP_VH
// ==========================================================================
// Word byte offsets
`define RPIS_OFS_IRQ1 6'h00
`define RPIS_OFS_IRQ2 6'h04
`define RPIS_OFS_TMR 6'h0c
`define RPIS_OFS_OSC 6'h10
`define RPIS_OFS_ANCFG 6'h14
`define RPIS_OFS_PULLUP 6'h18
`define RPIS_OFS_STATUS 6'h1c
// ==========================================================================
// Field positions
`define RPIS_HI_LSB 8
`define RPIS_LO_LSB 0
`define RPIS_FLD_W 5
`define RPIS_LOCK_BIT 6
// ==========================================================================
// Codes
`define RPIS_SEL_GND 5'h1f
`define RPIS_SEL_MAX 5'h19
`define RPIS_KEY1 8'h46
`define RPIS_KEY2 8'h57
`define RPIS_ANCFG_RST 16'h0000
`endif

// file: rpis_top.v
// Remappable input pin select with lock, shadow check and shared pin control.
`timescale 1ns/1ps
`include "rpis_map.vh"
// Contract
// [RULE1] Shared pins reset as analog
// [RULE2] Analog pin disables digital input buffer
// [RULE3] Analog pin reads digital zero
// [RULE4] Config bit one makes pin digital
// [RULE5] Digital only when all converters agree
// [RULE6] Output driver works even when analog
// [RULE7] Highest enabled function owns the pin; the code grants the pin to the lowest enabled index
// [RULE8] Each change pin has own pull-up
// [RULE9] At most twenty-three remap registers
// [RULE10] Selects writable only while lock clear
// [RULE11] Irq one field bits 12-8
// [RULE12] Irq two field bits 4-0
// [RULE13] Timer three 12-8, timer two 4-0
// [RULE14] Code n picks pin n, all-ones grounds
// [RULE15] Selectors reset to all ones
// [RULE16] Reserved codes drive constant low
// [RULE17] Lock toggles after 0x46, 0x57 keys
// [RULE18] Locked writes acknowledge but change nothing
// [RULE19] Shadow mismatch raises configuration reset
// [RULE20] Single session fuse keeps lock set
module rpis_top #(
  parameter NPINS = 26,
  parameter NSHARED = 16,
  parameter NADC = 2,
  parameter NFUNC = 3
) (
  // System
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // Wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [5:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // Fuse and pins
  input wire single_session_fuse_i,
  input wire [NPINS-1:0] remappable_pin_i,
  input wire [NSHARED-1:0] shared_pin_i,
  input wire [NSHARED*(NADC-1)-1:0] other_adc_cfg_i,
  input wire [NSHARED-1:0] port_out_i,
  input wire [NSHARED-1:0] pin_direction_reg_i,
  input wire [NFUNC-1:0] func_enable_i,
  // Peripheral inputs and pin controls
  output reg external_irq_one_o,
  output reg external_irq_two_o,
  output reg timer_two_ext_clock_o,
  output reg timer_three_ext_clock_o,
  output reg [NSHARED-1:0] digital_in_o,
  output reg [NSHARED-1:0] in_buf_en_o,
  output reg [NSHARED-1:0] pin_out_o,
  output reg [NSHARED-1:0] pin_oe_o,
  output reg [NFUNC-1:0] func_grant_o,
  output reg [NSHARED-1:0] pullup_en_o,
  output reg cfg_mismatch_rst_o
);
  // ========================================================================
  // Helpers
  function sel_pin;
    input [4:0] code;
    input [NPINS-1:0] pins;
    begin
      // [RULE14] Pin by code
      if (code <= `RPIS_SEL_MAX)
        sel_pin = pins[code];
      // [RULE16] Reserved is low
      else
        sel_pin = 1'b0;
    end
  endfunction

  // ========================================================================
  // Synchronisers
  reg [NPINS-1:0] rp_s1_q;
  reg [NPINS-1:0] rp_s2_q;
  reg [NSHARED-1:0] sh_s1_q;
  reg [NSHARED-1:0] sh_s2_q;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rp_s1_q <= {NPINS{1'b0}};
      rp_s2_q <= {NPINS{1'b0}};
      sh_s1_q <= {NSHARED{1'b0}};
      sh_s2_q <= {NSHARED{1'b0}};
    end
    else if (ce_i)
    begin
      rp_s1_q <= remappable_pin_i;
      rp_s2_q <= rp_s1_q;
      sh_s1_q <= shared_pin_i;
      sh_s2_q <= sh_s1_q;
    end
  end

  // ========================================================================
  // Registers
  // [RULE9] Three remap registers
  // Only three of the at most twenty-three remap registers are built here.
  reg [4:0] irq_one_pin_field_q;
  reg [4:0] irq_two_pin_field_q;
  reg [4:0] timer_three_clk_pin_field_q;
  reg [4:0] timer_two_clk_pin_field_q;
  reg [19:0] shadow_q;
  reg remap_write_lock_q;
  reg lock_was_set_q;
  reg [1:0] key_q;
  reg [15:0] analog_port_config_low_q;
  reg [15:0] pullup_q;
  reg [19:0] shadow_next;
  wire wr = cyc_i & stb_i & we_i & ~ack_o;
  wire sel_lo = sel_i[0];
  wire sel_hi = sel_i[1];
  wire [19:0] live = {irq_one_pin_field_q, irq_two_pin_field_q,
                      timer_three_clk_pin_field_q, timer_two_clk_pin_field_q};
  wire osc_wr = wr & sel_lo & (adr_i == `RPIS_OFS_OSC);
  wire [7:0] osc_byte = dat_i[7:0];
  wire new_lock = osc_byte[`RPIS_LOCK_BIT];
  wire lock_blocked = single_session_fuse_i & lock_was_set_q & ~new_lock;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // [RULE15] Selectors reset grounded
      irq_one_pin_field_q <= `RPIS_SEL_GND;
      irq_two_pin_field_q <= `RPIS_SEL_GND;
      timer_three_clk_pin_field_q <= `RPIS_SEL_GND;
      timer_two_clk_pin_field_q <= `RPIS_SEL_GND;
      shadow_q <= {4{`RPIS_SEL_GND}};
      remap_write_lock_q <= 1'b0;
      lock_was_set_q <= 1'b0;
      key_q <= 2'h0;
      // [RULE1] Analog after reset
      analog_port_config_low_q <= `RPIS_ANCFG_RST;
      pullup_q <= 16'h0000;
    end
    else if (ce_i)
    begin
      // [RULE17] Key sequence tracking
      if (osc_wr)
      begin
        if (key_q == 2'h2)
        begin
          // [RULE20] Fuse blocks clearing
          if (!lock_blocked)
            remap_write_lock_q <= new_lock;
          if (new_lock)
            lock_was_set_q <= 1'b1;
          key_q <= 2'h0;
        end
        else if (osc_byte == `RPIS_KEY1)
          key_q <= 2'h1;
        else if (key_q == 2'h1 && osc_byte == `RPIS_KEY2)
          key_q <= 2'h2;
        else
          key_q <= 2'h0;
      end
      else if (wr)
        key_q <= 2'h0;
      // [RULE10] Locked writes dropped, still acked
      if (wr && !remap_write_lock_q)
      begin
        // [RULE11] Irq one high byte
        if (adr_i == `RPIS_OFS_IRQ1 && sel_hi)
          irq_one_pin_field_q <= dat_i[`RPIS_HI_LSB +: `RPIS_FLD_W];
        // [RULE12] Irq two low byte
        if (adr_i == `RPIS_OFS_IRQ2 && sel_lo)
          irq_two_pin_field_q <= dat_i[`RPIS_LO_LSB +: `RPIS_FLD_W];
        // [RULE13] Timer fields
        if (adr_i == `RPIS_OFS_TMR && sel_hi)
          timer_three_clk_pin_field_q <= dat_i[`RPIS_HI_LSB +: `RPIS_FLD_W];
        if (adr_i == `RPIS_OFS_TMR && sel_lo)
          timer_two_clk_pin_field_q <= dat_i[`RPIS_LO_LSB +: `RPIS_FLD_W];
      end
      // Shadow takes the same legal updates, so only an upset parts them.
      shadow_q <= shadow_next;
      // [RULE4] Software sets digital
      if (wr && adr_i == `RPIS_OFS_ANCFG && sel_lo)
        analog_port_config_low_q[7:0] <= dat_i[7:0];
      if (wr && adr_i == `RPIS_OFS_ANCFG && sel_hi)
        analog_port_config_low_q[15:8] <= dat_i[15:8];
      // [RULE8] Independent pull-ups
      if (wr && adr_i == `RPIS_OFS_PULLUP && sel_lo)
        pullup_q[7:0] <= dat_i[7:0];
      if (wr && adr_i == `RPIS_OFS_PULLUP && sel_hi)
        pullup_q[15:8] <= dat_i[15:8];
    end
  end

  // Shadow next value mirrors the same write path as the live fields.
  always @*
  begin
    shadow_next = shadow_q;
    if (wr && !remap_write_lock_q)
    begin
      if (adr_i == `RPIS_OFS_IRQ1 && sel_hi)
        shadow_next[19:15] = dat_i[`RPIS_HI_LSB +: `RPIS_FLD_W];
      if (adr_i == `RPIS_OFS_IRQ2 && sel_lo)
        shadow_next[14:10] = dat_i[`RPIS_LO_LSB +: `RPIS_FLD_W];
      if (adr_i == `RPIS_OFS_TMR && sel_hi)
        shadow_next[9:5] = dat_i[`RPIS_HI_LSB +: `RPIS_FLD_W];
      if (adr_i == `RPIS_OFS_TMR && sel_lo)
        shadow_next[4:0] = dat_i[`RPIS_LO_LSB +: `RPIS_FLD_W];
    end
  end

  // ========================================================================
  // Bus answer
  reg [31:0] rd_d;
  always @*
  begin
    rd_d = 32'h00000000;
    case (adr_i)
      `RPIS_OFS_IRQ1: rd_d[`RPIS_HI_LSB +: `RPIS_FLD_W] = irq_one_pin_field_q;
      `RPIS_OFS_IRQ2: rd_d[`RPIS_LO_LSB +: `RPIS_FLD_W] = irq_two_pin_field_q;
      `RPIS_OFS_TMR:
      begin
        rd_d[`RPIS_HI_LSB +: `RPIS_FLD_W] = timer_three_clk_pin_field_q;
        rd_d[`RPIS_LO_LSB +: `RPIS_FLD_W] = timer_two_clk_pin_field_q;
      end
      `RPIS_OFS_OSC: rd_d[`RPIS_LOCK_BIT] = remap_write_lock_q;
      `RPIS_OFS_ANCFG: rd_d[15:0] = analog_port_config_low_q;
      `RPIS_OFS_PULLUP: rd_d[15:0] = pullup_q;
      `RPIS_OFS_STATUS: rd_d[2:0] = {key_q, lock_was_set_q};
      default: rd_d = 32'h00000000;
    endcase
  end

  // ========================================================================
  // Outputs
  wire [NSHARED-1:0] all_digital;
  genvar g;
  generate
    for (g = 0; g < NSHARED; g = g + 1)
    begin : g_pin
      wire [NADC-1:0] votes;
      assign votes[0] = analog_port_config_low_q[g];
      if (NADC > 1)
      begin : g_more
        assign votes[NADC-1:1] = other_adc_cfg_i[g*(NADC-1) +: NADC-1];
      end
      // [RULE5] All converters agree
      assign all_digital[g] = &votes;
    end
  endgenerate

  reg [NFUNC-1:0] grant_d;
  integer k;
  always @*
  begin
    grant_d = {NFUNC{1'b0}};
    // [RULE7] Lowest index wins
    for (k = NFUNC - 1; k >= 0; k = k - 1)
      if (func_enable_i[k])
        grant_d = {{(NFUNC-1){1'b0}}, 1'b1} << k;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dat_o <= 32'h00000000;
      ack_o <= 1'b0;
      external_irq_one_o <= 1'b0;
      external_irq_two_o <= 1'b0;
      timer_two_ext_clock_o <= 1'b0;
      timer_three_ext_clock_o <= 1'b0;
      digital_in_o <= {NSHARED{1'b0}};
      in_buf_en_o <= {NSHARED{1'b0}};
      pin_out_o <= {NSHARED{1'b0}};
      pin_oe_o <= {NSHARED{1'b0}};
      func_grant_o <= {NFUNC{1'b0}};
      pullup_en_o <= {NSHARED{1'b0}};
      cfg_mismatch_rst_o <= 1'b0;
    end
    else if (ce_i)
    begin
      // [RULE18] Every access acked
      ack_o <= cyc_i & stb_i & ~ack_o;
      dat_o <= rd_d;
      external_irq_one_o <= sel_pin(irq_one_pin_field_q, rp_s2_q);
      external_irq_two_o <= sel_pin(irq_two_pin_field_q, rp_s2_q);
      timer_two_ext_clock_o <= sel_pin(timer_two_clk_pin_field_q, rp_s2_q);
      timer_three_ext_clock_o <= sel_pin(timer_three_clk_pin_field_q, rp_s2_q);
      // [RULE2] Buffer off when analog
      in_buf_en_o <= all_digital;
      // [RULE3] Analog reads zero
      digital_in_o <= sh_s2_q & all_digital;
      // [RULE6] Driver ignores analog mode
      pin_out_o <= port_out_i;
      pin_oe_o <= ~pin_direction_reg_i;
      func_grant_o <= grant_d;
      pullup_en_o <= pullup_q;
      // [RULE19] Shadow compare
      cfg_mismatch_rst_o <= (live != shadow_q);
    end
  end
endmodule

// file: rpis_pins.sv
// Pin-side partner model driving remappable and shared pins.
`timescale 1ns/1ps
module rpis_pins (
  // Pattern control
  input wire logic [4:0] pick_i,
  input wire logic inv_i,
  // Pin levels
  output logic [25:0] remappable_pin_o,
  output logic [15:0] shared_pin_o
);
  // ==========================================================================
  // Pin levels
  // For pick 0 to 25 one pin differs from all others, so a wrong route shows up as a wrong level; larger picks leave all pins equal.
  assign remappable_pin_o = (26'h1 << pick_i) ^ {26{inv_i}};
  // Shared pins sit high, so any pin left analog must still read zero.
  assign shared_pin_o = 16'hffff;
endmodule

// file: rpis_chk_assertions.sv
// Port-level concurrent checks for the remappable input pin select block.
`timescale 1ns/1ps
module rpis_chk_assertions #(
  parameter NSHARED = 16,
  parameter NFUNC = 3
) (
  // System and bus
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire cyc_i,
  input wire stb_i,
  input wire ack_o,
  // Pins
  input wire [NSHARED-1:0] pin_direction_reg_i,
  input wire [NFUNC-1:0] func_enable_i,
  input wire [NSHARED-1:0] digital_in_o,
  input wire [NSHARED-1:0] in_buf_en_o,
  input wire [NSHARED-1:0] pin_oe_o,
  input wire [NFUNC-1:0] func_grant_o,
  input wire cfg_mismatch_rst_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================================
  // Bus handshake
  property p_ack_take; cyc_i && stb_i && !ack_o && ce_i |=> ack_o; endproperty
  a_ack_take: assert property (p_ack_take) else $error("ack missing after request");
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  // ==========================================================================
  // Pin control
  property p_analog_zero; (digital_in_o & ~in_buf_en_o) == '0; endproperty
  a_analog_zero: assert property (p_analog_zero) else $error("analog pin reads one");
  property p_reset_analog; $fell(rst_i) |-> in_buf_en_o == '0; endproperty
  a_reset_analog: assert property (p_reset_analog) else $error("buffer on after reset");
  property p_oe; ce_i && !$past(rst_i) |=> pin_oe_o == ~$past(pin_direction_reg_i); endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong");
  property p_grant;
    ce_i && !$past(rst_i) |=> func_grant_o == ($past(func_enable_i) & (~$past(func_enable_i) + 1'b1));
  endproperty
  a_grant: assert property (p_grant) else $error("wrong pin owner");
  property p_no_mismatch; !cfg_mismatch_rst_o; endproperty
  a_no_mismatch: assert property (p_no_mismatch) else $error("spurious mismatch reset");
  c_ack: cover property (ack_o);
  c_grant: cover property (func_grant_o[1]);
  c_digital: cover property (|digital_in_o);
endmodule
bind rpis_top rpis_chk_assertions #(.NSHARED(NSHARED), .NFUNC(NFUNC)) u_chk (.clk_i(clk_i),
  .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .pin_direction_reg_i(pin_direction_reg_i), .func_enable_i(func_enable_i),
  .digital_in_o(digital_in_o), .in_buf_en_o(in_buf_en_o), .pin_oe_o(pin_oe_o),
  .func_grant_o(func_grant_o), .cfg_mismatch_rst_o(cfg_mismatch_rst_o));

// file: remappable_input_pin_select_bench.sv
// Self-checking bench for the remappable input pin select block.
`timescale 1ns/1ps
`include "rpis_map.vh"
module remappable_input_pin_select_bench;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, inv = 0, ce = 1, fuse = 1;
  logic [3:0] sel = 4'h3;
  logic [5:0] adr = 0;
  logic [31:0] dat = 0, rd, dat_o;
  logic [4:0] pick = 0;
  logic [15:0] oadc = 16'hffff, pdir = 16'hffff, dig, ibuf, oe, pu, pout = 16'h0000, pin_q;
  logic [2:0] fen = 0, grant;
  logic [25:0] rpin;
  logic [15:0] spin;
  logic ack_o, irq1, irq2, t2, t3, mism;
  int err_total = 0, checks = 0, cyc_n = 0;
  rpis_pins u_pins (.pick_i(pick), .inv_i(inv), .remappable_pin_o(rpin), .shared_pin_o(spin));
  rpis_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .single_session_fuse_i(fuse), .remappable_pin_i(rpin), .shared_pin_i(spin),
    .other_adc_cfg_i(oadc), .port_out_i(pout), .pin_direction_reg_i(pdir),
    .func_enable_i(fen), .external_irq_one_o(irq1), .external_irq_two_o(irq2),
    .timer_two_ext_clock_o(t2), .timer_three_ext_clock_o(t3), .digital_in_o(dig),
    .in_buf_en_o(ibuf), .pin_out_o(pin_q), .pin_oe_o(oe), .func_grant_o(grant), .pullup_en_o(pu),
    .cfg_mismatch_rst_o(mism));
  initial forever #20 clk_i = ~clk_i;
  // ==========================================================================
  // Helpers
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hold the request until ack is sampled high; take read data and release on that edge.
  task wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc <= 0; stb <= 0;
  endtask
  task pins(input logic [4:0] p, input logic i);
    @(posedge clk_i);
    pick <= p; inv <= i;
    repeat (5) @(posedge clk_i);
  endtask
  // ==========================================================================
  // Scenarios
  task t_reset;
    wb(0, `RPIS_OFS_IRQ1, 0); chk(rd, 32'h1f00);
    wb(0, `RPIS_OFS_IRQ2, 0); chk(rd, 32'h001f);
    wb(0, `RPIS_OFS_TMR, 0); chk(rd, 32'h1f1f);
    wb(0, 6'h08, 0); chk(rd, 0);
    pins(0, 1); chk({irq1, irq2, t2, t3}, 0);
    $display("reset test done");
  endtask
  task t_route;
    logic [4:0] codes [4] = '{5'h00, 5'h19, 5'h1a, 5'h1e};
    wb(1, `RPIS_OFS_IRQ1, 32'hffff); wb(0, `RPIS_OFS_IRQ1, 0); chk(rd, 32'h1f00);
    foreach (codes[k])
    begin
      wb(1, `RPIS_OFS_IRQ1, {19'h0, codes[k], 8'h00});
      wb(1, `RPIS_OFS_IRQ2, {27'h0, codes[k]});
      wb(1, `RPIS_OFS_TMR, {19'h0, codes[k], 3'h0, codes[k]});
      pins(codes[k], 0); chk({irq1, irq2, t2, t3}, k < 2 ? 4'hf : 4'h0);
      pins(codes[k], 1); chk({irq1, irq2, t2, t3}, 0);
    end
    $display("route test done");
  endtask
  task t_pins;
    chk(ibuf, 0);
    oadc <= 16'hfffe; pdir <= 16'h00ff; fen <= 3'b110; pout <= 16'h3c3c;
    wb(1, `RPIS_OFS_ANCFG, 32'hffff); wb(1, `RPIS_OFS_PULLUP, 32'ha5a5);
    repeat (4) @(posedge clk_i);
    chk(dig, 16'hfffe);
    chk(ibuf, 16'hfffe);
    chk(oe, 16'hff00);
    chk(pin_q, 16'h3c3c);
    chk(grant, 3'b010);
    chk(pu, 16'ha5a5);
    $display("pin test done");
  endtask
  task t_lock;
    wb(1, `RPIS_OFS_OSC, `RPIS_KEY1); wb(1, `RPIS_OFS_OSC, `RPIS_KEY2);
    wb(1, `RPIS_OFS_OSC, 32'h40); wb(1, `RPIS_OFS_IRQ2, 32'h3);
    wb(0, `RPIS_OFS_IRQ2, 0); chk(rd, 32'h001e);
    wb(1, `RPIS_OFS_OSC, `RPIS_KEY1); wb(1, `RPIS_OFS_OSC, `RPIS_KEY2);
    wb(1, `RPIS_OFS_OSC, 32'h0); wb(0, `RPIS_OFS_OSC, 0); chk(rd[6], 1);
    // With the fuse open the lock may be cleared again.
    fuse <= 0;
    wb(1, `RPIS_OFS_OSC, `RPIS_KEY1); wb(1, `RPIS_OFS_OSC, `RPIS_KEY2);
    wb(1, `RPIS_OFS_OSC, 32'h0); wb(1, `RPIS_OFS_IRQ2, 32'h3);
    wb(0, `RPIS_OFS_IRQ2, 0); chk(rd, 32'h0003);
    sel <= 4'h1;
    wb(1, `RPIS_OFS_TMR, 32'h0505);
    sel <= 4'h3;
    wb(0, `RPIS_OFS_TMR, 0); chk(rd, 32'h1e05);
    chk(mism, 0);
    $display("lock test done");
  endtask
  task t_ce;
    pins(5'h03, 0); chk(irq2, 1);
    ce <= 0;
    pins(5'h03, 1); chk(irq2, 1);
    ce <= 1;
    repeat (5) @(posedge clk_i);
    chk(irq2, 0);
    $display("enable test done");
  endtask
  // ==========================================================================
  // Main sequence and hang guard
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n > 4000)
    begin
      err_total++;
      results;
    end
  end
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    t_reset;
    t_route;
    t_pins;
    t_lock;
    t_ce;
    results;
  end
endmodule
